// ### bench/rgc_global_command_asserts.sv
// Port assertions for the global command bits
`timescale 1ns/1ps
`include "rgc_defs.vh"
module rgc_global_command_asserts (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire root_pointer_load_req_o,
  input wire posted_write_flush_req_o,
  input wire queued_inval_enable_o,
  input wire intr_remap_enable_o,
  input wire intr_txn_idle_i,
  input wire intr_queue_empty_i,
  input wire intr_cache_inval_req_o
);
  wire gw = reg_wr_i && reg_addr_i == `RGC_GCMD_OFS;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_root_req: assert property (
    gw && reg_wdata_i[30] |=> root_pointer_load_req_o) else $error("no load");
  a_root_cause: assert property (
    root_pointer_load_req_o |-> $past(gw) && $past(reg_wdata_i[30]))
    else $error("stray load");
  a_flush_req: assert property (
    gw && reg_wdata_i[27] |=> posted_write_flush_req_o) else $error("no flush");
  a_flush_cause: assert property (
    posted_write_flush_req_o |-> $past(gw) && $past(reg_wdata_i[27]))
    else $error("stray flush");
  a_qinv_level: assert property (
    gw |=> queued_inval_enable_o == $past(reg_wdata_i[26]))
    else $error("bad qinv level");
  a_ir_boundary: assert property (
    $changed(intr_remap_enable_o) |-> $past(intr_txn_idle_i))
    else $error("remap switched off boundary");
  a_ir_drain: assert property (
    $rose(intr_remap_enable_o) |-> $past(intr_queue_empty_i))
    else $error("remap enabled before drain");
  a_inval_while_on: assert property (
    intr_cache_inval_req_o |-> intr_remap_enable_o)
    else $error("cache inval outside disable");
endmodule // rgc_global_command_asserts

bind rgc_global_command rgc_global_command_asserts i_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .root_pointer_load_req_o(root_pointer_load_req_o),
  .posted_write_flush_req_o(posted_write_flush_req_o),
  .queued_inval_enable_o(queued_inval_enable_o),
  .intr_remap_enable_o(intr_remap_enable_o),
  .intr_txn_idle_i(intr_txn_idle_i), .intr_queue_empty_i(intr_queue_empty_i),
  .intr_cache_inval_req_o(intr_cache_inval_req_o));

// ### bench/tb_top.sv
// Self-checking bench for the global command bits
`timescale 1ns/1ps
`include "rgc_defs.vh"
module tb_top;
  logic ref_clk_i = 0;
  logic reset_i = 1;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0;
  logic wr = 0, rd = 0, rp_done = 0, wb_done = 0, qi_ack = 0;
  logic idle = 0, empty = 0, ic_done = 0;
  logic [31:0] rdata;
  logic [63:0] rt_addr;
  logic rp_req, wb_req, qi_en, ir_en, ic_req;
  int errors = 0, total_checks = 0, n;
  always #2.5 ref_clk_i = ~ref_clk_i;
  rgc_global_command i_rgc_global_command (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .root_table_address_o(rt_addr), .root_pointer_load_req_o(rp_req),
    .root_pointer_load_done_i(rp_done), .posted_write_flush_req_o(wb_req),
    .posted_write_flush_done_i(wb_done), .queued_inval_enable_o(qi_en),
    .queued_inval_ack_i(qi_ack), .intr_remap_enable_o(ir_en),
    .intr_txn_idle_i(idle), .intr_queue_empty_i(empty),
    .intr_cache_inval_req_o(ic_req), .intr_cache_inval_done_i(ic_done));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    wr <= 0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    rd <= 1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 0;
    #1;
    chk(rdata, exp);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task wait_ir(input logic v);
    for (n = 0; n < 50 && ir_en !== v; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk(ir_en, v);
    if (n == 50) end_of_test;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 0;
    rd_reg(`RGC_GSTS_OFS, 0);
    wr_reg(`RGC_RTADDR_LO_OFS, 32'h89abc000);
    wr_reg(`RGC_RTADDR_HI_OFS, 32'h00000012);
    rd_reg(`RGC_RTADDR_LO_OFS, 32'h89abc000);
    rd_reg(`RGC_RTADDR_HI_OFS, 32'h00000012);
    rd_reg(`RGC_CAP_OFS, 32'h0000000f);
    rd_reg(`RGC_GCMD_OFS, 0);
    wr_reg(`RGC_GCMD_OFS, 32'h40000000);
    chk(rp_req, 1);
    chk(rt_addr, 64'h0000001289abc000);
    rd_reg(`RGC_GSTS_OFS, 0);
    @(posedge ref_clk_i) rp_done <= 1;
    @(posedge ref_clk_i) rp_done <= 0;
    rd_reg(`RGC_GSTS_OFS, 32'h40000000);
    wr_reg(`RGC_GCMD_OFS, 0);
    chk({rp_req, wb_req}, 0);
    rd_reg(`RGC_GSTS_OFS, 32'h40000000);
    wr_reg(`RGC_GCMD_OFS, 32'h08000000);
    chk(wb_req, 1);
    rd_reg(`RGC_GSTS_OFS, 32'h48000000);
    @(posedge ref_clk_i) wb_done <= 1;
    @(posedge ref_clk_i) wb_done <= 0;
    rd_reg(`RGC_GSTS_OFS, 32'h40000000);
    wr_reg(`RGC_GCMD_OFS, 32'h04000000);
    chk(qi_en, 1);
    @(posedge ref_clk_i) qi_ack <= 1;
    @(posedge ref_clk_i) qi_ack <= 0;
    rd_reg(`RGC_GSTS_OFS, 32'h44000000);
    // Queue busy and no boundary yet: the enable has to hold off
    wr_reg(`RGC_GCMD_OFS, 32'h06000000);
    repeat (8) @(posedge ref_clk_i);
    chk(ir_en, 0);
    @(posedge ref_clk_i) empty <= 1;
    repeat (8) @(posedge ref_clk_i);
    chk(ir_en, 0);
    @(posedge ref_clk_i) idle <= 1;
    wait_ir(1);
    rd_reg(`RGC_GSTS_OFS, 32'h46000000);
    wr_reg(`RGC_GCMD_OFS, 32'h04000000);
    chk({ic_req, ir_en}, 2'b11);
    @(posedge ref_clk_i) ic_done <= 1;
    @(posedge ref_clk_i) ic_done <= 0;
    wait_ir(0);
    rd_reg(`RGC_GSTS_OFS, 32'h44000000);
    rd_reg(12'h0f0, 0);
    end_of_test;
  end
endmodule // tb_top

// ### common/rgc_defs.vh
// Offsets, field positions and reset values of the global command bits
`ifndef RGC_DEFS_VH
`define RGC_DEFS_VH

// Register byte offsets
`define RGC_GCMD_OFS 12'h018
`define RGC_GSTS_OFS 12'h01c
`define RGC_RTADDR_LO_OFS 12'h020
`define RGC_RTADDR_HI_OFS 12'h024
`define RGC_CAP_OFS 12'h030

// Field positions in command and status words
`define RGC_ROOT_PTR_BIT 30
`define RGC_FLUSH_BIT 27
`define RGC_QINV_BIT 26
`define RGC_IREMAP_BIT 25

// Capability word bit positions (own layout)
`define RGC_CAP_FLUSH_BIT 0
`define RGC_CAP_QINV_BIT 1
`define RGC_CAP_IREMAP_BIT 2
`define RGC_CAP_ESIRT_BIT 3

// Reset values
`define RGC_RTADDR_RST 64'h0000000000000000
`define RGC_STATUS_RST 32'h00000000

`endif

// ### logic/rgc_global_command.v
// Global command bits 30, 27, 26 and 25 of a remapping unit with matching status
`timescale 1ns/1ps

module rgc_global_command #(
  parameter HAS_FLUSH = 1,
  parameter HAS_QINV = 1,
  parameter HAS_IREMAP = 1,
  parameter HAS_ESIRT = 1
) (
  input wire ref_clk_i,
  input wire reset_i,
  // Register port
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Root pointer load towards the translation engine
  output reg [63:0] root_table_address_o,
  output reg root_pointer_load_req_o,
  input wire root_pointer_load_done_i,
  // Posted write flush
  output reg posted_write_flush_req_o,
  input wire posted_write_flush_done_i,
  // Queued invalidation engine
  output reg queued_inval_enable_o,
  input wire queued_inval_ack_i,
  // Interrupt remapping
  output reg intr_remap_enable_o,
  input wire intr_txn_idle_i,
  input wire intr_queue_empty_i,
  output reg intr_cache_inval_req_o,
  input wire intr_cache_inval_done_i
);

`include "rgc_defs.vh"

  // ---------------------------------------------------------------
  // Interrupt remap switch states
  // ---------------------------------------------------------------
  localparam IR_IDLE = 4'b0001;
  localparam IR_DRAIN = 4'b0010;
  localparam IR_INVAL = 4'b0100;
  localparam IR_SWITCH = 4'b1000;

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Partial decode would alias the command word onto its neighbours,
  // so every register is matched on the full byte address
  wire sel_gcmd = hit(reg_addr_i, `RGC_GCMD_OFS);
  wire sel_gsts = hit(reg_addr_i, `RGC_GSTS_OFS);
  wire sel_rtlo = hit(reg_addr_i, `RGC_RTADDR_LO_OFS);
  wire sel_rthi = hit(reg_addr_i, `RGC_RTADDR_HI_OFS);
  wire sel_cap = hit(reg_addr_i, `RGC_CAP_OFS);
  wire gcmd_wr = reg_wr_i & sel_gcmd;
  wire [31:0] wd = reg_wdata_i;

  // ---------------------------------------------------------------
  // Root table address register and root pointer load
  // ---------------------------------------------------------------
  reg [63:0] rtaddr_q;
  reg [63:0] rtaddr_d;
  reg [63:0] root_addr_d;
  reg root_req_d;
  reg root_busy_q;
  reg root_busy_d;
  reg root_status_q;
  reg root_status_d;

  // Only a written one in bit 30 starts a load; zero there leaves the root state alone
  wire root_cmd = gcmd_wr & wd[`RGC_ROOT_PTR_BIT];

  always @* begin
    rtaddr_d = rtaddr_q;
    if (reg_wr_i && sel_rtlo) begin
      rtaddr_d[31:0] = reg_wdata_i;
    end else if (reg_wr_i && sel_rthi) begin
      rtaddr_d[63:32] = reg_wdata_i;
    end
  end

  // The engine gets a snapshot, so later address writes cannot
  // disturb a load already in flight
  // A done pulse outside a load is ignored, so a late or stray
  // acknowledge cannot fake a completed pointer update
  always @* begin
    root_addr_d = root_table_address_o;
    root_req_d = root_cmd;
    root_busy_d = root_busy_q;
    root_status_d = root_status_q;
    if (root_cmd) begin
      root_addr_d = rtaddr_q;
      root_busy_d = 1'b1;
      root_status_d = 1'b0;
    end else if (root_busy_q && root_pointer_load_done_i) begin
      root_busy_d = 1'b0;
      root_status_d = 1'b1;
    end
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rtaddr_q <= `RGC_RTADDR_RST;
      root_table_address_o <= `RGC_RTADDR_RST;
      root_pointer_load_req_o <= 1'b0;
      root_busy_q <= 1'b0;
      root_status_q <= 1'b0;
    end else begin
      rtaddr_q <= rtaddr_d;
      root_table_address_o <= root_addr_d;
      root_pointer_load_req_o <= root_req_d;
      root_busy_q <= root_busy_d;
      root_status_q <= root_status_d;
    end
  end

  // ---------------------------------------------------------------
  // Posted write flush
  // ---------------------------------------------------------------
  reg flush_status_q;
  reg flush_status_d;
  wire flush_cmd = gcmd_wr & wd[`RGC_FLUSH_BIT] &
    (HAS_FLUSH != 0);

  // A new command wins over a done seen in the same cycle
  // The flush status is a plain level; software polls it until it
  // drops, there is no completion event of its own
  always @* begin
    flush_status_d = flush_status_q;
    if (flush_cmd) begin
      flush_status_d = 1'b1;
    end else if (posted_write_flush_done_i) begin
      flush_status_d = 1'b0;
    end
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      posted_write_flush_req_o <= 1'b0;
      flush_status_q <= 1'b0;
    end else begin
      posted_write_flush_req_o <= flush_cmd;
      flush_status_q <= flush_status_d;
    end
  end

  // ---------------------------------------------------------------
  // Queued invalidation enable
  // ---------------------------------------------------------------
  reg qinv_status_q;
  reg qinv_status_d;
  reg qinv_enable_d;

  // The enable level is stored even when it equals the old one;
  // the engine's ack then simply repeats the current state
  always @* begin
    qinv_enable_d = queued_inval_enable_o;
    qinv_status_d = qinv_status_q;
    if (gcmd_wr && HAS_QINV != 0) begin
      qinv_enable_d = wd[`RGC_QINV_BIT];
    end
    // Status follows the engine once it acknowledges the new level
    if (queued_inval_ack_i) begin
      qinv_status_d = queued_inval_enable_o;
    end
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      queued_inval_enable_o <= 1'b0;
      qinv_status_q <= 1'b0;
    end else begin
      queued_inval_enable_o <= qinv_enable_d;
      qinv_status_q <= qinv_status_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt remap enable
  // ---------------------------------------------------------------
  reg [3:0] ir_state_q;
  reg [3:0] ir_state_d;
  reg ir_target_q;
  reg ir_target_d;
  reg ir_status_q;
  reg ir_status_d;
  reg ir_enable_d;
  reg ir_inval_d;

  // Writes to the enable field while a switch is under way are
  // dropped; software must poll the status before writing again
  // The drain and boundary inputs are trusted as given; a partner
  // that never raises them leaves the switch pending for ever
  always @* begin
    ir_state_d = ir_state_q;
    ir_target_d = ir_target_q;
    ir_status_d = ir_status_q;
    ir_enable_d = intr_remap_enable_o;
    ir_inval_d = 1'b0;
    case (ir_state_q)
      IR_IDLE: begin
        if (gcmd_wr && HAS_IREMAP != 0 &&
            wd[`RGC_IREMAP_BIT] != intr_remap_enable_o) begin
          ir_target_d = wd[`RGC_IREMAP_BIT];
          if (wd[`RGC_IREMAP_BIT]) begin
            ir_state_d = IR_DRAIN;
          end else if (HAS_ESIRT != 0) begin
            ir_inval_d = 1'b1;
            ir_state_d = IR_INVAL;
          end else begin
            ir_state_d = IR_SWITCH;
          end
        end
      end
      IR_DRAIN: begin
        // Queued requests must leave before status shows enabled
        if (intr_queue_empty_i) begin
          ir_state_d = IR_SWITCH;
        end
      end
      IR_INVAL: begin
        if (intr_cache_inval_done_i) begin
          ir_state_d = IR_SWITCH;
        end
      end
      IR_SWITCH: begin
        // Flip only between interrupts so none is half remapped
        if (intr_txn_idle_i) begin
          ir_enable_d = ir_target_q;
          ir_status_d = ir_target_q;
          ir_state_d = IR_IDLE;
        end
      end
      default: begin
        ir_state_d = IR_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ir_state_q <= IR_IDLE;
      ir_target_q <= 1'b0;
      ir_status_q <= 1'b0;
      intr_remap_enable_o <= 1'b0;
      intr_cache_inval_req_o <= 1'b0;
    end else begin
      ir_state_q <= ir_state_d;
      ir_target_q <= ir_target_d;
      ir_status_q <= ir_status_d;
      intr_remap_enable_o <= ir_enable_d;
      intr_cache_inval_req_o <= ir_inval_d;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Status word built from the root, flush, queued invalidation and remap status flags
  function [31:0] status_word;
    input root_s;
    input flush_s;
    input qinv_s;
    input ir_s;
    begin
      status_word = `RGC_STATUS_RST;
      status_word[`RGC_ROOT_PTR_BIT] = root_s;
      status_word[`RGC_FLUSH_BIT] = flush_s;
      status_word[`RGC_QINV_BIT] = qinv_s;
      status_word[`RGC_IREMAP_BIT] = ir_s;
    end
  endfunction

  // Capability word built from the feature parameters
  function [31:0] cap_word;
    input flush_c;
    input qinv_c;
    input ir_c;
    input esirt_c;
    begin
      cap_word = 32'h00000000;
      cap_word[`RGC_CAP_FLUSH_BIT] = flush_c;
      cap_word[`RGC_CAP_QINV_BIT] = qinv_c;
      cap_word[`RGC_CAP_IREMAP_BIT] = ir_c;
      cap_word[`RGC_CAP_ESIRT_BIT] = esirt_c;
    end
  endfunction

  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    // Command word reads as zero; software must not rely on it
    if (sel_gsts) begin
      rd_d = status_word(root_status_q, flush_status_q, qinv_status_q,
        ir_status_q);
    end else if (sel_rtlo) begin
      rd_d = rtaddr_q[31:0];
    end else if (sel_rthi) begin
      rd_d = rtaddr_q[63:32];
    end else if (sel_cap) begin
      rd_d = cap_word(HAS_FLUSH != 0, HAS_QINV != 0, HAS_IREMAP != 0,
        HAS_ESIRT != 0);
    end
  end

  // Read data are registered and held for one cycle only; an idle
  // bus reads as zero so stale status never lingers on the port
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= `RGC_STATUS_RST;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_d;
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // rgc_global_command
